// file: rtl/drps_pkg.sv
package drps_pkg;

  // register offsets on the plain register port
  localparam logic [3:0] DRPS_ADDR_CTRL    = 4'h0; // start, burn, seq select
  localparam logic [3:0] DRPS_ADDR_CONFIG  = 4'h1; // freq, spread, pump stage
  localparam logic [3:0] DRPS_ADDR_SRC_SET = 4'h2; // positive source target
  localparam logic [3:0] DRPS_ADDR_GON_SET = 4'h3; // positive gate target
  localparam logic [3:0] DRPS_ADDR_GOF_SET = 4'h4; // negative gate target
  localparam logic [3:0] DRPS_ADDR_DELAY   = 4'h5; // three step delays
  localparam logic [3:0] DRPS_ADDR_STATUS  = 4'h6; // rails, state, flags

  // ctrl register fields
  localparam int DRPS_CTRL_START_BIT = 0;
  localparam int DRPS_CTRL_BURN_BIT  = 1;
  localparam int DRPS_CTRL_SEQ_LSB   = 4;

  // config register fields
  localparam int DRPS_CFG_FREQ_BIT = 0;
  localparam int DRPS_CFG_SS_BIT   = 1;
  localparam int DRPS_CFG_PUMP_BIT = 2;

  // delay register: three 4-bit fields, ms each
  localparam int DRPS_DLY_ONE_LSB   = 0;
  localparam int DRPS_DLY_TWO_LSB   = 4;
  localparam int DRPS_DLY_THREE_LSB = 8;

  // reset and unprogrammed defaults
  localparam logic [2:0] DRPS_SEQ_RESET     = 3'h2;
  localparam logic [5:0] DRPS_SRC_DEFAULT   = 6'h18; // code for 6.8 V
  localparam logic [5:0] DRPS_GON_DEFAULT   = 6'h20; // code for 12 V
  localparam logic [5:0] DRPS_GOF_DEFAULT   = 6'h22; // code for -10 V
  localparam logic [3:0] DRPS_DELAY_DEFAULT = 4'h0;

  // address-select strap levels
  localparam logic [1:0] DRPS_ADDR_SEL_LOW   = 2'h0;
  localparam logic [1:0] DRPS_ADDR_SEL_FLOAT = 2'h1;
  localparam logic [1:0] DRPS_ADDR_SEL_HIGH  = 2'h2;
  localparam logic [6:0] DRPS_RO_DEV_ADDR    = 7'h29;

  // timing
  localparam int  DRPS_CLK_HZ        = 20000000;
  localparam int  DRPS_MS_CYCLES     = DRPS_CLK_HZ / 1000;
  localparam int  DRPS_WAKE_MS       = 1;
  localparam int  DRPS_OFF_GAP_MS    = 1;
  localparam int  DRPS_SHUTDOWN_MS   = 200;
  localparam int  DRPS_WAKE_CYCLES   = DRPS_WAKE_MS * DRPS_MS_CYCLES;
  localparam int  DRPS_SHDN_CYCLES   = DRPS_SHUTDOWN_MS * DRPS_MS_CYCLES;

  // rail bit positions in a rail mask
  localparam int DRPS_RAIL_PSRC = 0;
  localparam int DRPS_RAIL_NSRC = 1;
  localparam int DRPS_RAIL_PGT  = 2; // with common buffer
  localparam int DRPS_RAIL_NGT  = 3;

  typedef enum {
    DRPS_ST_OFF,
    DRPS_ST_WAKE,
    DRPS_ST_IDLE,
    DRPS_ST_ON_STEP,
    DRPS_ST_ON_WAIT,
    DRPS_ST_RUN,
    DRPS_ST_OFF_STEP,
    DRPS_ST_OFF_WAIT,
    DRPS_ST_SHDN_WAIT
  } drps_state_e;

  // analog settings handed to the regulators
  typedef struct packed {
    logic       switch_freq_select;
    logic       spread_enable;
    logic       pump_doubler_select;
    logic [5:0] src_target;
    logic [5:0] pos_gate_target;
    logic [5:0] neg_gate_target;
  } drps_analog_s;

  // stored nonvolatile image
  typedef struct packed {
    logic       written;
    logic [2:0] seq;
    logic [3:0] step_delay_one;
    logic [3:0] step_delay_two;
    logic [3:0] step_delay_three;
    logic [2:0] cfg;
    logic [5:0] src;
    logic [5:0] gon;
    logic [5:0] gof;
  } drps_nv_s;

endpackage : drps_pkg

// file: rtl/drps_sequencer.sv
`timescale 1ns/1ps
// Function
// - after power, stay low-current with all rails off until enable rises
// - enable high with supply above lockout: start core regulator, wait 1 ms
// - host variant with strap low/high waits for start bit before rails
// - strap floating: rails come up at once with stored values
// - auto-start variant: rails up at once whatever the strap
// - auto-start with strap high: reads only, writes refused, address 0x29
// - programmed memory: load stored settings and use stored sequence
// - blank memory: start with default rail targets
// - burn commits written settings only on explicit request, t1 and t3 swapped in the stored image
// - core regulator out of range sets flag and pulls fault low in serial mode
// - frequency bit selects 2.1 MHz when 0, 420 kHz when 1
// - spread-spectrum bit modulates switching frequency when set
// - pump stage bit turns positive gate tripler into doubler
// - 6-bit positive source target; negative source tracks it
// - 6-bit positive and negative gate targets, host-writable, storable
// - 3-bit sequence select among eight orders, reset code 010
// - codes 000..101 enable four steps spaced by t1, t2, t3
// - codes 110/111 enable sources together then two gate steps
// - power-off reverses power-on, waiting t3, t2, t1 (codes 110/111 wait t3, t2)
// - three delay fields set step waits; zero means no wait at power-on
// - power-off steps on time only; zero delay still spaces 1 ms
// - burn also commits the selected sequence
// - 200 ms after power-off, core regulator off, shutdown until enable
// - enable low means shutdown, enable high means active
// - serial mode fault output low only while the core regulator out-of-range flag is set
module drps_sequencer #(
  parameter bit AUTO_START_VARIANT = 1'b0,
  parameter int WAKE_CYCLES        = drps_pkg::DRPS_WAKE_CYCLES,
  parameter int SHDN_CYCLES        = drps_pkg::DRPS_SHDN_CYCLES,
  parameter int MS_CYCLES          = drps_pkg::DRPS_MS_CYCLES
) (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_b_in,
  // pins and analog status
  input  wire logic                   enable_in,
  input  wire logic [1:0]             addr_sel_in,
  input  wire logic                   supply_ok_in,
  input  wire logic                   core_reg_bad_in,
  // nonvolatile image
  input  wire drps_pkg::drps_nv_s     nv_image_in,
  output logic                        nv_burn_out,
  output drps_pkg::drps_nv_s          nv_write_out,
  // register port
  input  wire logic [3:0]             reg_addr_in,
  input  wire logic [15:0]            reg_wdata_in,
  input  wire logic                   reg_wr_in,
  input  wire logic                   reg_rd_in,
  output logic [15:0]                 reg_rdata_out,
  // serial interface mode
  output logic                        serial_read_only_out,
  output logic [6:0]                  serial_dev_addr_out,
  // regulators
  output logic                        core_regulator_rail_out,
  output logic [3:0]                  rail_enable_out,
  output drps_pkg::drps_analog_s      analog_out,
  // fault pin, open drain
  output logic                        fault_out_n_out,
  output logic                        fault_out_n_oe_b_out
);
  import drps_pkg::*;

  typedef struct packed {
    logic [2:0]  en_sync;
    logic [2:0]  bad_sync;
    logic        en_q;
    logic        bad_q;
    drps_state_e state;
    logic [23:0] cnt;
    logic [1:0]  step;
    logic        start;
    logic [2:0]  seq;
    logic [11:0] delays;
    drps_analog_s ana;
    logic [3:0]  rails;
    logic        core_on;
    logic        core_reg_out_of_range;
    logic        burn;
    logic [15:0] rdata;
    logic        strap_seen;
    logic [1:0]  strap;
  } drps_core_s;

  drps_core_s st_reg;
  drps_core_s st_next;

  // rail mask for one power-on step of a sequence code
  function automatic logic [3:0] step_mask(input logic [2:0] code, input logic [1:0] idx);
    logic [3:0] m;
    m = 4'h0;
    case (code)
      3'h0: case (idx) 2'h0: m = 4'h1; 2'h1: m = 4'h2; 2'h2: m = 4'h8; default: m = 4'h4; endcase
      3'h1: case (idx) 2'h0: m = 4'h1; 2'h1: m = 4'h2; 2'h2: m = 4'h4; default: m = 4'h8; endcase
      3'h2: case (idx) 2'h0: m = 4'h2; 2'h1: m = 4'h1; 2'h2: m = 4'h8; default: m = 4'h4; endcase
      3'h3: case (idx) 2'h0: m = 4'h2; 2'h1: m = 4'h1; 2'h2: m = 4'h4; default: m = 4'h8; endcase
      3'h4: case (idx) 2'h0: m = 4'h2; 2'h1: m = 4'h8; 2'h2: m = 4'h1; default: m = 4'h4; endcase
      3'h5: case (idx) 2'h0: m = 4'h8; 2'h1: m = 4'h4; 2'h2: m = 4'h2; default: m = 4'h1; endcase
      3'h6: case (idx) 2'h0: m = 4'h3; 2'h1: m = 4'h8; 2'h2: m = 4'h4; default: m = 4'h0; endcase
      default: case (idx) 2'h0: m = 4'h3; 2'h1: m = 4'h4; 2'h2: m = 4'h8; default: m = 4'h0; endcase
    endcase
    return m;
  endfunction

  // delay in ms before power-on step idx (1..3)
  function automatic logic [3:0] gap_ms(input logic [11:0] d, input logic [1:0] idx);
    case (idx)
      2'h1:    gap_ms = d[DRPS_DLY_ONE_LSB +: 4];
      2'h2:    gap_ms = d[DRPS_DLY_TWO_LSB +: 4];
      default: gap_ms = d[DRPS_DLY_THREE_LSB +: 4];
    endcase
  endfunction

  logic        strap_serial;
  logic        read_only;
  logic        auto_go;
  logic [1:0]  last_step;
  logic [3:0]  ms_val;
  logic [23:0] wait_cyc;
  logic        en_now;
  logic        bad_now;

  // strap decode and filtered pins; sync stage 0 is never read here
  always_comb begin
    strap_serial = (st_reg.strap != DRPS_ADDR_SEL_FLOAT);
    read_only    = AUTO_START_VARIANT && (st_reg.strap == DRPS_ADDR_SEL_HIGH);
    auto_go      = AUTO_START_VARIANT || !strap_serial;
    last_step    = st_reg.seq[2] && st_reg.seq[1] ? 2'h2 : 2'h3;
    en_now       = (st_reg.en_sync[1] == st_reg.en_sync[2]) ? st_reg.en_sync[2] : st_reg.en_q;
    bad_now      = (st_reg.bad_sync[1] == st_reg.bad_sync[2]) ? st_reg.bad_sync[2] : st_reg.bad_q;
  end

  always_comb begin
    st_next          = st_reg;
    ms_val           = 4'h0;
    wait_cyc         = 24'h0;
    st_next.en_sync  = {st_reg.en_sync[1:0], enable_in};
    st_next.bad_sync = {st_reg.bad_sync[1:0], core_reg_bad_in};
    st_next.en_q     = en_now;
    st_next.bad_q    = bad_now;
    st_next.burn     = 1'b0;
    st_next.core_reg_out_of_range = st_reg.core_on && bad_now;
    st_next.rdata    = 16'h0;

    // register writes; refused in read-only strap mode
    if (reg_wr_in && !read_only) begin
      case (reg_addr_in)
        DRPS_ADDR_CTRL: begin
          st_next.start = st_reg.start | reg_wdata_in[DRPS_CTRL_START_BIT];
          st_next.burn  = reg_wdata_in[DRPS_CTRL_BURN_BIT];
          st_next.seq   = reg_wdata_in[DRPS_CTRL_SEQ_LSB +: 3];
        end
        DRPS_ADDR_CONFIG: begin
          st_next.ana.switch_freq_select  = reg_wdata_in[DRPS_CFG_FREQ_BIT];
          st_next.ana.spread_enable       = reg_wdata_in[DRPS_CFG_SS_BIT];
          st_next.ana.pump_doubler_select = reg_wdata_in[DRPS_CFG_PUMP_BIT];
        end
        DRPS_ADDR_SRC_SET: st_next.ana.src_target      = reg_wdata_in[5:0];
        DRPS_ADDR_GON_SET: st_next.ana.pos_gate_target = reg_wdata_in[5:0];
        DRPS_ADDR_GOF_SET: st_next.ana.neg_gate_target = reg_wdata_in[5:0];
        DRPS_ADDR_DELAY:   st_next.delays              = reg_wdata_in[11:0];
        default: ;
      endcase
    end

    // register reads, data one cycle later; unmapped reads give zero
    if (reg_rd_in) begin
      case (reg_addr_in)
        DRPS_ADDR_CTRL:    st_next.rdata = {9'h0, st_reg.seq, 3'h0, st_reg.start};
        DRPS_ADDR_CONFIG:  st_next.rdata = {13'h0, st_reg.ana.pump_doubler_select,
                                            st_reg.ana.spread_enable,
                                            st_reg.ana.switch_freq_select};
        DRPS_ADDR_SRC_SET: st_next.rdata = {10'h0, st_reg.ana.src_target};
        DRPS_ADDR_GON_SET: st_next.rdata = {10'h0, st_reg.ana.pos_gate_target};
        DRPS_ADDR_GOF_SET: st_next.rdata = {10'h0, st_reg.ana.neg_gate_target};
        DRPS_ADDR_DELAY:   st_next.rdata = {4'h0, st_reg.delays};
        DRPS_ADDR_STATUS:  st_next.rdata = {7'h0, st_reg.core_reg_out_of_range,
                                            4'(st_reg.state), st_reg.rails};
        default:           st_next.rdata = 16'h0;
      endcase
    end

    if (st_reg.cnt != 24'h0) begin
      st_next.cnt = st_reg.cnt - 24'h1;
    end

    // sequencing state machine
    case (st_reg.state)
      DRPS_ST_OFF: begin
        st_next.rails   = 4'h0;
        st_next.core_on = 1'b0;
        st_next.start   = 1'b0;
        if (en_now && supply_ok_in) begin
          st_next.core_on = 1'b1;
          st_next.cnt     = 24'(WAKE_CYCLES);
          st_next.state   = DRPS_ST_WAKE;
        end
      end
      DRPS_ST_WAKE: begin
        if (!en_now) begin
          st_next.state = DRPS_ST_OFF;
        end else if (st_reg.cnt == 24'h0) begin
          st_next.strap      = addr_sel_in; // strap caught when the wake delay ends
          st_next.strap_seen = 1'b1;
          if (nv_image_in.written) begin
            st_next.seq    = nv_image_in.seq;
            st_next.delays = {nv_image_in.step_delay_three, nv_image_in.step_delay_two,
                              nv_image_in.step_delay_one};
            st_next.ana    = {nv_image_in.cfg, nv_image_in.src, nv_image_in.gon,
                              nv_image_in.gof};
          end else begin
            st_next.ana.src_target      = DRPS_SRC_DEFAULT;
            st_next.ana.pos_gate_target = DRPS_GON_DEFAULT;
            st_next.ana.neg_gate_target = DRPS_GOF_DEFAULT;
          end
          st_next.state = DRPS_ST_IDLE;
        end
      end
      DRPS_ST_IDLE: begin
        if (!en_now) begin
          st_next.cnt   = 24'(SHDN_CYCLES);
          st_next.state = DRPS_ST_SHDN_WAIT;
        end else if (auto_go || st_reg.start) begin
          st_next.step  = 2'h0;
          st_next.state = DRPS_ST_ON_STEP;
        end
      end
      DRPS_ST_ON_STEP: begin
        st_next.rails = st_reg.rails | step_mask(st_reg.seq, st_reg.step);
        if (st_reg.step == last_step) begin
          st_next.state = DRPS_ST_RUN;
        end else begin
          st_next.step  = st_reg.step + 2'h1;
          ms_val        = gap_ms(st_reg.delays, st_reg.step + 2'h1);
          wait_cyc      = 24'(ms_val) * 24'(MS_CYCLES);
          st_next.cnt   = wait_cyc;
          st_next.state = DRPS_ST_ON_WAIT;
        end
        if (!en_now) begin
          st_next.step  = st_reg.step;
          st_next.cnt   = 24'h0;
          st_next.state = DRPS_ST_OFF_STEP;
        end
      end
      DRPS_ST_ON_WAIT: begin
        if (!en_now) begin
          st_next.step  = st_reg.step - 2'h1;
          st_next.cnt   = 24'h0;
          st_next.state = DRPS_ST_OFF_WAIT;
        end else if (st_reg.cnt == 24'h0) begin
          st_next.state = DRPS_ST_ON_STEP;
        end
      end
      DRPS_ST_RUN: begin
        if (!en_now) begin
          st_next.step  = last_step;
          st_next.state = DRPS_ST_OFF_STEP;
        end
      end
      DRPS_ST_OFF_STEP: begin
        st_next.rails = st_reg.rails & ~step_mask(st_reg.seq, st_reg.step);
        if (st_reg.step == 2'h0) begin
          st_next.cnt   = 24'(SHDN_CYCLES);
          st_next.state = DRPS_ST_SHDN_WAIT;
        end else begin
          // three-step codes still wait t3 then t2, so their index moves up one
          ms_val = gap_ms(st_reg.delays, st_reg.step + (last_step == 2'h2 ? 2'h1 : 2'h0));
          if (ms_val == 4'h0) begin
            ms_val = 4'(DRPS_OFF_GAP_MS);
          end
          wait_cyc      = 24'(ms_val) * 24'(MS_CYCLES);
          st_next.cnt   = wait_cyc;
          st_next.step  = st_reg.step - 2'h1;
          st_next.state = DRPS_ST_OFF_WAIT;
        end
      end
      DRPS_ST_OFF_WAIT: begin
        if (st_reg.cnt == 24'h0) begin
          st_next.state = DRPS_ST_OFF_STEP;
        end
      end
      DRPS_ST_SHDN_WAIT: begin
        if (st_reg.cnt == 24'h0) begin
          st_next.core_on = 1'b0;
          st_next.state   = DRPS_ST_OFF;
        end
      end
      default: st_next.state = DRPS_ST_OFF;
    endcase
  end

  // whole block state, one register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg        <= '0;
      st_reg.state  <= DRPS_ST_OFF;
      st_reg.seq    <= DRPS_SEQ_RESET;
      st_reg.strap  <= DRPS_ADDR_SEL_FLOAT;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  always_comb begin
    reg_rdata_out           = st_reg.rdata;
    serial_read_only_out    = read_only;
    serial_dev_addr_out     = read_only ? DRPS_RO_DEV_ADDR : 7'h0;
    core_regulator_rail_out = st_reg.core_on;
    rail_enable_out         = st_reg.rails;
    analog_out              = st_reg.ana;
    nv_burn_out             = st_reg.burn;
    nv_write_out            = {1'b1, st_reg.seq, st_reg.delays[11:8], st_reg.delays[7:4],
                               st_reg.delays[3:0], st_reg.ana.switch_freq_select,
                               st_reg.ana.spread_enable, st_reg.ana.pump_doubler_select,
                               st_reg.ana.src_target, st_reg.ana.pos_gate_target,
                               st_reg.ana.neg_gate_target};
    fault_out_n_out         = 1'b0;
    // open drain: enable low pulls the pin low
    fault_out_n_oe_b_out    = !(strap_serial && st_reg.core_reg_out_of_range);
  end

endmodule // drps_sequencer

// file: verif/drps_nv_model.sv
`timescale 1ns/1ps
module drps_nv_model (
  // clock
  input  wire logic               clk_in,
  // burn request and image to store
  input  wire logic               burn_in,
  input  wire drps_pkg::drps_nv_s write_in,
  // stored image
  output drps_pkg::drps_nv_s      image_out
);
  import drps_pkg::*;

  // starts blank; survives reset since the cells are nonvolatile
  drps_nv_s mem = '0;

  // store only on an explicit burn pulse
  always @(posedge clk_in) begin
    if (burn_in) begin
      mem <= write_in;
    end
  end

  assign image_out = mem;
endmodule // drps_nv_model

// file: verif/drps_sequencer_assertions.sv
`timescale 1ns/1ps
module drps_sequencer_assertions (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  // watched inputs
  input wire logic        core_reg_bad_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  // watched outputs
  input wire logic [15:0] reg_rdata_out,
  input wire logic        nv_burn_out,
  input wire logic        serial_read_only_out,
  input wire logic [6:0]  serial_dev_addr_out,
  input wire logic        core_regulator_rail_out,
  input wire logic [3:0]  rail_enable_out,
  input wire logic        fault_out_n_out,
  input wire logic        fault_out_n_oe_b_out
);
  import drps_pkg::*;

  logic [3:0] rail_prev_reg;
  logic       burn_req_reg;
  logic       rail_up;
  logic       rail_down;

  // last rail mask and decoded burn write, one cycle old
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rail_prev_reg <= 4'h0;
      burn_req_reg  <= 1'b0;
    end else begin
      rail_prev_reg <= rail_enable_out;
      burn_req_reg  <= reg_wr_in && (reg_addr_in == DRPS_ADDR_CTRL)
                       && reg_wdata_in[DRPS_CTRL_BURN_BIT];
    end
  end

  // rail edges seen this cycle
  assign rail_up   = |(rail_enable_out & ~rail_prev_reg);
  assign rail_down = |(rail_prev_reg & ~rail_enable_out);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  AST_RDATA_ONLY_AFTER_READ: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside its cycle");
  AST_RAILS_NEED_CORE: assert property (!core_regulator_rail_out |-> rail_enable_out == 4'h0)
    else $error("rail on without core regulator");
  AST_WAKE_HOLDS_RAILS: assert property ($rose(core_regulator_rail_out) |-> (rail_enable_out == 4'h0) [*8])
    else $error("rail on during wake delay");
  AST_NO_MIXED_STEP: assert property (!(rail_up && rail_down))
    else $error("rails rose and fell together");
  AST_OFF_STEP_SPACING: assert property (rail_down |=> !rail_down [*8])
    else $error("power-off steps too close");
  AST_CORE_HOLD_AFTER_OFF: assert property ($fell(|rail_enable_out) |-> core_regulator_rail_out [*8])
    else $error("core regulator dropped early");
  AST_BURN_ON_REQUEST: assert property (nv_burn_out == (burn_req_reg && !serial_read_only_out))
    else $error("burn pulse without matching write");
  AST_READ_ONLY_ADDRESS: assert property (serial_dev_addr_out == (serial_read_only_out ? DRPS_RO_DEV_ADDR : 7'h00))
    else $error("serial address mismatch");
  AST_FAULT_RELEASED: assert property (!core_reg_bad_in [*8] |-> fault_out_n_oe_b_out)
    else $error("fault pin held without cause");
  AST_FAULT_DRIVES_LOW: assert property (fault_out_n_out == 1'b0)
    else $error("open drain drives high");

  // main scenarios reached
  cover property (rail_enable_out == 4'hf);
  cover property (nv_burn_out);
  cover property ($fell(fault_out_n_oe_b_out));
  cover property ($fell(core_regulator_rail_out));
endmodule // drps_sequencer_assertions

bind drps_sequencer drps_sequencer_assertions u_drps_sequencer_assertions (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .core_reg_bad_in(core_reg_bad_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .nv_burn_out(nv_burn_out),
  .serial_read_only_out(serial_read_only_out), .serial_dev_addr_out(serial_dev_addr_out),
  .core_regulator_rail_out(core_regulator_rail_out), .rail_enable_out(rail_enable_out),
  .fault_out_n_out(fault_out_n_out), .fault_out_n_oe_b_out(fault_out_n_oe_b_out)
);

// file: verif/test_display_rail_power_sequencer.sv
`timescale 1ns/1ps
module test_display_rail_power_sequencer;
  import drps_pkg::*;
  localparam int MS = 10;
  // rail bits per step, first step in the low nibble
  localparam logic [15:0] ORD [8] = '{16'h4821, 16'h8421, 16'h4812, 16'h8412,
                                      16'h4182, 16'h1248, 16'h0483, 16'h0843};
  logic         clk_in = 1'b0;
  logic         rst_b_in = 1'b0;
  logic         enable_in = 1'b0;
  logic         supply_ok_in = 1'b1;
  logic         core_reg_bad_in = 1'b0;
  logic [1:0]   addr_sel_in = DRPS_ADDR_SEL_LOW;
  logic [3:0]   reg_addr_in = 4'h0;
  logic [15:0]  reg_wdata_in = 16'h0000;
  logic         reg_wr_in = 1'b0;
  logic         reg_rd_in = 1'b0;
  logic [15:0]  reg_rdata_out, d;
  logic         nv_burn_out, serial_read_only_out, core_regulator_rail_out;
  logic         fault_out_n_out, fault_out_n_oe_b_out;
  logic [6:0]   serial_dev_addr_out;
  logic [3:0]   rail_enable_out;
  drps_analog_s analog_out;
  drps_nv_s     nv_image_in, nv_write_out;
  wire          fault_pin = fault_out_n_oe_b_out ? 1'b1 : fault_out_n_out; // pull-up
  int           errors = 0, total_checks = 0, cyc = 0, t[3];
  logic [31:0]  rs = 32'h5824;
  logic [5:0]   src, gon, gof;
  logic [2:0]   cfg;

  drps_sequencer #(.AUTO_START_VARIANT(1'b0), .WAKE_CYCLES(20), .SHDN_CYCLES(200),
    .MS_CYCLES(MS)) u_drps_sequencer (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .enable_in(enable_in), .addr_sel_in(addr_sel_in),
    .supply_ok_in(supply_ok_in), .core_reg_bad_in(core_reg_bad_in),
    .nv_image_in(nv_image_in), .nv_burn_out(nv_burn_out), .nv_write_out(nv_write_out),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .serial_read_only_out(serial_read_only_out), .serial_dev_addr_out(serial_dev_addr_out),
    .core_regulator_rail_out(core_regulator_rail_out), .rail_enable_out(rail_enable_out),
    .analog_out(analog_out), .fault_out_n_out(fault_out_n_out),
    .fault_out_n_oe_b_out(fault_out_n_oe_b_out));
  drps_nv_model u_drps_nv_model (.clk_in(clk_in), .burn_in(nv_burn_out),
    .write_in(nv_write_out), .image_out(nv_image_in));

  // clock and hang guard
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask

  // follow each rail step, checking mask and spacing; off gaps never below 1 ms
  task automatic seq(input int code, input bit on, input int lo0, input int hi0);
    logic [3:0] m, s, p;
    int nst, k, n, g, h;
    m = on ? 4'h0 : 4'hf;
    nst = (code >= 6) ? 3 : 4;
    for (k = 0; k < nst; k++) begin
      s = ORD[code][(on ? k : nst - 1 - k) * 4 +: 4];
      m = on ? (m | s) : (m & ~s);
      g = (k == 0) ? lo0 : on ? t[k-1] * MS : ((t[3-k] == 0) ? 1 : t[3-k]) * MS;
      h = (k == 0) ? hi0 : g + 2;
      p = rail_enable_out;
      n = 0;
      while (rail_enable_out === p && n < h + 8) begin
        tick(1);
        n++;
      end
      check(rail_enable_out, m, "rail step mask");
      check(n >= g && n <= h, 1, "rail step spacing");
    end
  endtask

  task automatic power_up(input logic [1:0] s);
    int n;
    @(posedge clk_in);
    addr_sel_in <= s;
    enable_in   <= 1'b1;
    n = 0;
    while (core_regulator_rail_out !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check(core_regulator_rail_out, 1, "core regulator on");
  endtask

  task automatic power_down(input int code);
    int n;
    @(posedge clk_in);
    enable_in <= 1'b0;
    seq(code, 0, 0, 10);
    n = 0;
    while (core_regulator_rail_out === 1'b1 && n < 260) begin
      tick(1);
      n++;
    end
    check(n >= 199 && n <= 210, 1, "core regulator off delay");
  endtask

  // main sequence: serial strap, every ordering, burn, then standalone restart
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    tick(20);
    check({core_regulator_rail_out, rail_enable_out}, 0, "idle before enable");
    supply_ok_in <= 1'b0;
    enable_in    <= 1'b1;
    tick(10);
    check(core_regulator_rail_out, 0, "core held in lockout");
    supply_ok_in <= 1'b1;
    power_up(DRPS_ADDR_SEL_LOW);
    tick(100);
    check(rail_enable_out, 0, "rails wait for start");
    check(serial_dev_addr_out, 0, "writable serial address");
    rd(DRPS_ADDR_SRC_SET);
    check(d[5:0], DRPS_SRC_DEFAULT, "default source");
    rd(DRPS_ADDR_GON_SET);
    check(d[5:0], DRPS_GON_DEFAULT, "default positive gate");
    rd(DRPS_ADDR_GOF_SET);
    check(d[5:0], DRPS_GOF_DEFAULT, "default negative gate");
    rd(DRPS_ADDR_CTRL);
    check(d[6:4], DRPS_SEQ_RESET, "sequence reset code");
    rd(4'hf);
    check(d, 0, "unmapped read");
    core_reg_bad_in <= 1'b1;
    tick(10);
    check(fault_pin, 0, "fault pin pulled");
    rd(DRPS_ADDR_STATUS);
    check(d[8], 1, "out of range flag");
    core_reg_bad_in <= 1'b0;
    tick(10);
    check(fault_pin, 1, "fault pin released");
    for (int c = 0; c < 8; c++) begin
      if (c > 0) power_up(DRPS_ADDR_SEL_LOW);
      tick(30);
      for (int i = 0; i < 3; i++) begin
        rs = xs(rs);
        t[i] = rs % 3;
      end
      rs = xs(rs);
      {cfg, src, gon, gof} = rs[20:0];
      wr(DRPS_ADDR_DELAY, {4'h0, 4'(t[2]), 4'(t[1]), 4'(t[0])});
      wr(DRPS_ADDR_CONFIG, {13'h0, cfg});
      wr(DRPS_ADDR_SRC_SET, {10'h0, src});
      wr(DRPS_ADDR_GON_SET, {10'h0, gon});
      wr(DRPS_ADDR_GOF_SET, {10'h0, gof});
      tick(2);
      check(analog_out, {cfg[0], cfg[1], cfg[2], src, gon, gof}, "analog");
      check(nv_image_in.written, 0, "image untouched");
      wr(DRPS_ADDR_CTRL, {9'h0, 3'(c), 4'h1});
      seq(c, 1, 0, 10);
      if (c == 7) begin
        wr(DRPS_ADDR_CTRL, 16'h0073);
        tick(3);
        check({nv_image_in.written, nv_image_in.seq, nv_image_in.src}, {1'b1, 3'h7, src},
              "burned image");
      end
      power_down(c);
    end
    power_up(DRPS_ADDR_SEL_FLOAT);
    seq(7, 1, 19, 30);
    core_reg_bad_in <= 1'b1;
    rd(DRPS_ADDR_SRC_SET);
    check(d[5:0], src, "stored source target");
    tick(8);
    check(fault_pin, 1, "standalone pin left free");
    core_reg_bad_in <= 1'b0;
    power_down(7);
    conclude();
  end
endmodule // test_display_rail_power_sequencer
